// ==== hw/psp_defs.svh ====
`ifndef PSP_DEFS_SVH
`define PSP_DEFS_SVH

// ************************************************************
// Sizes
// ************************************************************
`define PSP_NUM_PORTS       4
`define PSP_PD_MAX_BYTES    32
`define PSP_LEN_W           6
`define PSP_ADDR_W          12

// ************************************************************
// Register byte addresses
// ************************************************************
`define PSP_ADDR_MOD_STATUS 12'h000
`define PSP_ADDR_PORT_STAT  12'h004
`define PSP_ADDR_CTRL       12'h008
`define PSP_ADDR_CFG        12'h00C
`define PSP_ADDR_MAP        12'h010
`define PSP_ADDR_PD_LEN     12'h014
`define PSP_ADDR_IRQ_STAT   12'h018
`define PSP_ADDR_IRQ_MASK   12'h01C
`define PSP_ADDR_PD_BASE    12'h100

// ************************************************************
// Field positions
// ************************************************************
`define PSP_MS_EVENT_BIT    0
`define PSP_MS_STATE_LSB    8
`define PSP_MS_STATE_MSB    15
`define PSP_SB_MODE_LSB     0
`define PSP_SB_MODE_MSB     1
`define PSP_SB_LVL_BIT      2
`define PSP_SB_INV_BIT      3
`define PSP_SB_ERR_LSB      4
`define PSP_SB_ERR_MSB      7
`define PSP_CTRL_ACK_BIT    0
`define PSP_CTRL_RELOAD_BIT 1
`define PSP_IRQ_W           3
`define PSP_IRQ_EVENT_BIT   0
`define PSP_IRQ_CYCLE_BIT   1
`define PSP_IRQ_RELOAD_BIT  2

// ************************************************************
// Reset values
// ************************************************************
`define PSP_RST_BYTE        8'h00
`define PSP_RST_WORD        32'h0000_0000
`define PSP_RST_IRQ         3'h0

`endif

// ==== hw/psp_pkg.sv ====
package psp_pkg;

   typedef enum logic [1:0] {
      PSP_MODE_OFF  = 2'b00,
      PSP_MODE_DIN  = 2'b01,
      PSP_MODE_DOUT = 2'b10,
      PSP_MODE_OPER = 2'b11
   } psp_mode_t;

   typedef enum logic [3:0] {
      PSP_ERR_NONE     = 4'b0000,
      PSP_ERR_WDOG     = 4'b0001,
      PSP_ERR_INTERNAL = 4'b0010,
      PSP_ERR_DEV_ID   = 4'b0011,
      PSP_ERR_VEND_ID  = 4'b0100,
      PSP_ERR_VERSION  = 4'b0101,
      PSP_ERR_FRAME    = 4'b0110,
      PSP_ERR_CYCLE    = 4'b0111,
      PSP_ERR_IN_LEN   = 4'b1000,
      PSP_ERR_OUT_LEN  = 4'b1001,
      PSP_ERR_NO_DEV   = 4'b1010,
      PSP_ERR_PRE_OPERATE_PHASE    = 4'b1011
   } psp_err_t;

   typedef enum logic [1:0] {
      PSP_BUS_IDLE = 2'b00,
      PSP_BUS_RESP = 2'b01
   } psp_bus_t;

endpackage : psp_pkg

// ==== hw/psp_pd_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "psp_defs.svh"
module psp_pd_mem #(
   parameter int WORDS = 32,
   parameter int AW    = 5
) (
   // Clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   // Write side
   input  wire logic          wen,
   input  wire logic [3:0]    wbe,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [31:0]   wdata,
   // Read side
   input  wire logic [AW-1:0] raddr,
   output logic      [31:0]   rdata
);

   wire logic [31:0] rd_lanes;

   if (WORDS < 1 || (1 << AW) < WORDS) begin : g_bad_size
      $error("WORDS must fit the address width");
   end

   // Byte lanes kept apart so each lane has a single writer
   genvar b;
   for (b = 0; b < 4; b++) begin : g_lane
      logic [7:0] lane_q [WORDS];
      logic [7:0] lane_rd_ff;
      always_ff @(posedge core_clk) begin
         if (wen && wbe[b]) begin
            lane_q[waddr] <= wdata[8*b +: 8];
         end
      end
      // Registered read, one cycle after the address
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            lane_rd_ff <= `PSP_RST_BYTE;
         end else begin
            lane_rd_ff <= lane_q[raddr];
         end
      end
      assign rd_lanes[8*b +: 8] = lane_rd_ff;
   end

   assign rdata = rd_lanes;

endmodule : psp_pd_mem
`default_nettype wire

// ==== hw/psp_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "psp_defs.svh"
module psp_top #(
   parameter int NUM_PORTS    = `PSP_NUM_PORTS,
   parameter int PD_MAX_BYTES = `PSP_PD_MAX_BYTES,
   localparam int PW          = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1,
   localparam int LW          = $clog2(PD_MAX_BYTES)
) (
   // Clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        rst_n,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [`PSP_ADDR_W-1:0]      paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Port condition from the link master logic
   input  wire psp_pkg::psp_mode_t          port_mode     [NUM_PORTS],
   input  wire psp_pkg::psp_err_t           port_err      [NUM_PORTS],
   input  wire logic [`PSP_LEN_W-1:0]       port_pd_len   [NUM_PORTS],
   input  wire logic [NUM_PORTS-1:0]        port_halted,
   input  wire logic [NUM_PORTS-1:0]        port_pd_valid,
   input  wire logic [NUM_PORTS-1:0]        port_event,
   // Port pins sampled in plain digital mode
   input  wire logic [NUM_PORTS-1:0]        port_din_pin,
   // Process data byte stream from the link master logic
   input  wire logic                        pd_wr_valid,
   input  wire logic [PW-1:0]               pd_wr_port,
   input  wire logic [LW-1:0]               pd_wr_idx,
   input  wire logic [7:0]                  pd_wr_data,
   // Module state and fieldbus cycle
   input  wire logic [7:0]                  module_state,
   input  wire logic                        fb_cycle,
   // Interrupt
   output logic                             irq
);
   import psp_pkg::*;

   // ************************************************************
   // Derived sizes and parameter checks
   // ************************************************************
   localparam int WPP    = PD_MAX_BYTES / 4;
   localparam int NWORDS = NUM_PORTS * WPP;
   localparam int AW     = $clog2(NWORDS);
   localparam int PD_END = `PSP_ADDR_PD_BASE + NUM_PORTS * PD_MAX_BYTES;

   // Port status word holds four bytes; length field is six bits wide
   if (NUM_PORTS < 1 || NUM_PORTS > 4) begin : g_bad_ports
      $error("NUM_PORTS must be 1 to 4");
   end
   if (PD_MAX_BYTES < 4 || PD_MAX_BYTES > 32 || (PD_MAX_BYTES & (PD_MAX_BYTES - 1)) != 0) begin : g_bad_len
      $error("PD_MAX_BYTES must be a power of two from 4 to 32");
   end
   if (NWORDS < 2) begin : g_bad_words
      $error("process data memory needs at least two words");
   end

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [NUM_PORTS-1:0]  din_meta_ff;
   logic [NUM_PORTS-1:0]  din_sync_ff;
   logic [7:0]            nxt_status_byte [NUM_PORTS];
   logic [7:0]            status_byte_ff  [NUM_PORTS];
   logic [7:0]            module_state_ff;
   logic                  event_ff;
   logic                  nxt_event;
   logic                  event_vis_ff;
   logic [NUM_PORTS-1:0]  cfg_pend_ff;
   logic [NUM_PORTS-1:0]  act_mask_ff;
   logic [`PSP_LEN_W-1:0] act_len_ff [NUM_PORTS];
   logic [`PSP_IRQ_W-1:0] irq_stat_ff;
   logic [`PSP_IRQ_W-1:0] irq_mask_ff;
   logic [`PSP_IRQ_W-1:0] irq_set;
   logic                  irq_ff;
   psp_bus_t              bus_state_ff;
   logic [31:0]           prdata_ff;
   logic                  pready_ff;
   logic                  pslverr_ff;
   logic                  acc_take;
   logic                  wr_commit;
   logic                  ack_wr;
   logic                  reload_wr;
   logic                  any_event;
   logic [31:0]           port_stat_word;
   logic [31:0]           map_word;
   logic [31:0]           len_word;
   logic [31:0]           rd_word;
   logic                  addr_ok;
   logic                  pd_hit;
   logic [`PSP_ADDR_W-1:0] pd_off;
   logic [PW-1:0]         rd_port;
   logic [LW-1:0]         rd_byte;
   logic [31:0]           pd_word;
   logic [31:0]           mem_rdata;
   logic                  mem_wen;
   logic [3:0]            mem_wbe;
   logic [AW-1:0]         mem_waddr;
   logic [AW-1:0]         mem_raddr;

   // ************************************************************
   // Pin synchroniser for digital input level
   // ************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         din_meta_ff <= '0;
         din_sync_ff <= '0;
      end else begin
         din_meta_ff <= port_din_pin;
         din_sync_ff <= din_meta_ff;
      end
   end

   // ************************************************************
   // Per-port status byte
   // ************************************************************
   genvar p;
   for (p = 0; p < NUM_PORTS; p++) begin : g_port
      always_comb begin
         nxt_status_byte[p] = `PSP_RST_BYTE;
         nxt_status_byte[p][`PSP_SB_MODE_MSB:`PSP_SB_MODE_LSB] = port_mode[p];
         // Level bit means input level in plain mode, halt otherwise
         if (port_mode[p] == PSP_MODE_DIN || port_mode[p] == PSP_MODE_DOUT) begin
            nxt_status_byte[p][`PSP_SB_LVL_BIT] = din_sync_ff[p];
         end else begin
            nxt_status_byte[p][`PSP_SB_LVL_BIT] = port_halted[p];
         end
         nxt_status_byte[p][`PSP_SB_INV_BIT] = ~port_pd_valid[p];
         // Codes above the defined set fold into internal error
         if (port_err[p] > PSP_ERR_PRE_OPERATE_PHASE) begin
            nxt_status_byte[p][`PSP_SB_ERR_MSB:`PSP_SB_ERR_LSB] = PSP_ERR_INTERNAL;
         end else begin
            nxt_status_byte[p][`PSP_SB_ERR_MSB:`PSP_SB_ERR_LSB] = port_err[p];
         end
      end

      // Snapshot per fieldbus cycle keeps the four bytes coherent
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            status_byte_ff[p] <= `PSP_RST_BYTE;
         end else if (fb_cycle) begin
            status_byte_ff[p] <= nxt_status_byte[p];
         end
      end

      // Active mapping changes only on reload
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            act_len_ff[p] <= '0;
         end else if (reload_wr) begin
            if (!cfg_pend_ff[p]) begin
               act_len_ff[p] <= '0;
            end else if (port_pd_len[p] > `PSP_LEN_W'(PD_MAX_BYTES)) begin
               act_len_ff[p] <= `PSP_LEN_W'(PD_MAX_BYTES);
            end else begin
               act_len_ff[p] <= port_pd_len[p];
            end
         end
      end
   end

   always_comb begin
      port_stat_word = `PSP_RST_WORD;
      map_word       = `PSP_RST_WORD;
      len_word       = `PSP_RST_WORD;
      for (int i = 0; i < NUM_PORTS; i++) begin
         port_stat_word[8*i +: 8] = status_byte_ff[i];
         map_word[i]              = act_mask_ff[i];
         len_word[8*i +: 8]       = 8'(act_len_ff[i]);
      end
   end

   // ************************************************************
   // Module status and event flag
   // ************************************************************
   assign any_event = |port_event;

   // A new event in the acknowledge cycle keeps the flag set
   always_comb begin
      nxt_event = event_ff;
      if (ack_wr) begin
         nxt_event = 1'b0;
      end
      if (any_event) begin
         nxt_event = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         event_ff <= 1'b0;
      end else begin
         event_ff <= nxt_event;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         event_vis_ff    <= 1'b0;
         module_state_ff <= `PSP_RST_BYTE;
      end else if (fb_cycle) begin
         event_vis_ff    <= nxt_event;
         module_state_ff <= module_state;
      end else if (ack_wr) begin
         event_vis_ff    <= nxt_event;
      end
   end

   // ************************************************************
   // Configuration and mapping
   // ************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_pend_ff <= '0;
      end else if (wr_commit && paddr == `PSP_ADDR_CFG) begin
         cfg_pend_ff <= pwdata[NUM_PORTS-1:0];
      end
   end

   // Empty mask: only the two status objects are mapped
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         act_mask_ff <= '0;
      end else if (reload_wr) begin
         act_mask_ff <= cfg_pend_ff;
      end
   end

   // ************************************************************
   // Interrupts
   // ************************************************************
   always_comb begin
      irq_set                      = `PSP_RST_IRQ;
      irq_set[`PSP_IRQ_EVENT_BIT]  = any_event;
      irq_set[`PSP_IRQ_CYCLE_BIT]  = fb_cycle;
      irq_set[`PSP_IRQ_RELOAD_BIT] = reload_wr;
   end

   // Write one to clear; a set in the same cycle wins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_ff <= `PSP_RST_IRQ;
      end else if (wr_commit && paddr == `PSP_ADDR_IRQ_STAT) begin
         irq_stat_ff <= (irq_stat_ff & ~pwdata[`PSP_IRQ_W-1:0]) | irq_set;
      end else begin
         irq_stat_ff <= irq_stat_ff | irq_set;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_ff <= `PSP_RST_IRQ;
      end else if (wr_commit && paddr == `PSP_ADDR_IRQ_MASK) begin
         irq_mask_ff <= pwdata[`PSP_IRQ_W-1:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   // ************************************************************
   // Process data memory
   // ************************************************************
   assign mem_wen   = pd_wr_valid && (int'(pd_wr_port) < NUM_PORTS);
   assign mem_wbe   = 4'h1 << pd_wr_idx[1:0];
   assign mem_waddr = AW'(int'(pd_wr_port) * WPP + int'(pd_wr_idx >> 2));
   assign pd_off    = paddr - `PSP_ADDR_PD_BASE;
   assign mem_raddr = pd_off[AW+1:2];
   assign rd_port   = PW'(int'(pd_off) / PD_MAX_BYTES);
   assign rd_byte   = pd_off[LW-1:0];
   assign pd_hit    = (paddr >= `PSP_ADDR_PD_BASE) && (int'(paddr) < PD_END) && (paddr[1:0] == 2'b00);

   psp_pd_mem #(
      .WORDS (NWORDS),
      .AW    (AW)
   ) u_pd_mem (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wen      (mem_wen),
      .wbe      (mem_wbe),
      .waddr    (mem_waddr),
      .wdata    ({4{pd_wr_data}}),
      .raddr    (mem_raddr),
      .rdata    (mem_rdata)
   );

   // Bytes past the active length, or of unmapped ports, read zero
   always_comb begin
      pd_word = `PSP_RST_WORD;
      if (pd_hit && act_mask_ff[rd_port]) begin
         for (int b = 0; b < 4; b++) begin
            if (int'(rd_byte) + b < int'(act_len_ff[rd_port])) begin
               pd_word[8*b +: 8] = mem_rdata[8*b +: 8];
            end
         end
      end
   end

   // ************************************************************
   // APB slave
   // ************************************************************
   assign acc_take  = (bus_state_ff == PSP_BUS_RESP) && psel && penable;
   assign wr_commit = acc_take && pwrite && !pslverr_ff;
   assign ack_wr    = wr_commit && paddr == `PSP_ADDR_CTRL && pwdata[`PSP_CTRL_ACK_BIT];
   assign reload_wr = wr_commit && paddr == `PSP_ADDR_CTRL && pwdata[`PSP_CTRL_RELOAD_BIT];

   always_comb begin
      rd_word = `PSP_RST_WORD;
      addr_ok = 1'b1;
      if (paddr == `PSP_ADDR_MOD_STATUS) begin
         rd_word[`PSP_MS_EVENT_BIT] = event_vis_ff;
         rd_word[`PSP_MS_STATE_MSB:`PSP_MS_STATE_LSB] = module_state_ff;
      end else if (paddr == `PSP_ADDR_PORT_STAT) begin
         rd_word = port_stat_word;
      end else if (paddr == `PSP_ADDR_CTRL) begin
         rd_word = `PSP_RST_WORD;
      end else if (paddr == `PSP_ADDR_CFG) begin
         rd_word[NUM_PORTS-1:0] = cfg_pend_ff;
      end else if (paddr == `PSP_ADDR_MAP) begin
         rd_word = map_word;
      end else if (paddr == `PSP_ADDR_PD_LEN) begin
         rd_word = len_word;
      end else if (paddr == `PSP_ADDR_IRQ_STAT) begin
         rd_word[`PSP_IRQ_W-1:0] = irq_stat_ff;
      end else if (paddr == `PSP_ADDR_IRQ_MASK) begin
         rd_word[`PSP_IRQ_W-1:0] = irq_mask_ff;
      end else if (pd_hit) begin
         rd_word = pd_word;
      end else begin
         addr_ok = 1'b0;
      end
   end

   // One wait state lets the memory read settle behind a register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_state_ff <= PSP_BUS_IDLE;
         pready_ff    <= 1'b0;
         pslverr_ff   <= 1'b0;
         prdata_ff    <= `PSP_RST_WORD;
      end else begin
         case (bus_state_ff)
            PSP_BUS_IDLE: begin
               if (psel && penable) begin
                  bus_state_ff <= PSP_BUS_RESP;
                  pready_ff    <= 1'b1;
                  pslverr_ff   <= ~addr_ok;
                  prdata_ff    <= (pwrite || !addr_ok) ? `PSP_RST_WORD : rd_word;
               end
            end
            PSP_BUS_RESP: begin
               bus_state_ff <= PSP_BUS_IDLE;
               pready_ff    <= 1'b0;
               pslverr_ff   <= 1'b0;
               prdata_ff    <= `PSP_RST_WORD;
            end
            default: begin
               bus_state_ff <= PSP_BUS_IDLE;
               pready_ff    <= 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Slave toward the controller, master logic feeds the port inputs
   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq     = irq_ff;

endmodule : psp_top
`default_nettype wire

// ==== tb/psp_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "psp_defs.svh"
module psp_top_sva (
   // Clock and reset
   input wire logic                   core_clk,
   input wire logic                   rst_n,
   // APB
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [`PSP_ADDR_W-1:0] paddr,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ************************************************************
   // Handshake and status objects
   // ************************************************************
   property p_wait;
      psel && penable && !pready |=> pready;
   endproperty
   a_wait: assert property (p_wait) else $error("no answer after one wait state");
   property p_once;
      pready |=> !pready;
   endproperty
   a_once: assert property (p_once) else $error("pready longer than one cycle");
   property p_setup;
      $rose(psel) |-> !pready;
   endproperty
   a_setup: assert property (p_setup) else $error("pready in setup cycle");
   property p_zero;
      !pready |-> prdata == 32'h0000_0000;
   endproperty
   a_zero: assert property (p_zero) else $error("read data outside answer");
   property p_errack;
      pslverr |-> pready && psel && penable;
   endproperty
   a_errack: assert property (p_errack) else $error("error without answer");
   property p_unal;
      pready && paddr[1:0] != 2'h0 |-> pslverr;
   endproperty
   a_unal: assert property (p_unal) else $error("unaligned access accepted");
   property p_gap;
      pready && paddr inside {[12'h020:12'h0FC]} |-> pslverr;
   endproperty
   a_gap: assert property (p_gap) else $error("unmapped access accepted");
   property p_msw;
      pready && !pwrite && paddr == `PSP_ADDR_MOD_STATUS |-> prdata[31:16] == 16'h0 && prdata[7:1] == 7'h0;
   endproperty
   a_msw: assert property (p_msw) else $error("module status wider than two bytes");
   property p_psw;
      pready && paddr == `PSP_ADDR_PORT_STAT |-> !pslverr;
   endproperty
   a_psw: assert property (p_psw) else $error("port status refused");
endmodule : psp_top_sva
`default_nettype wire

// ==== tb/psp_fb_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module psp_fb_master (
   // Clock
   input wire logic         core_clk,
   // APB master
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input wire logic [31:0]  prdata,
   input wire logic         pready,
   input wire logic         pslverr,
   // Cycle strobe
   output logic             fb_cycle
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      fb_cycle = 1'b0;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e, output logic ok);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      ok = 1'b0;
      for (n = 0; n < 20 && !ok; n++) begin
         @(posedge core_clk);
         ok = (pready === 1'b1);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle bus shows no stale value
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
   task automatic cyc;
      @(posedge core_clk);
      fb_cycle <= 1'b1;
      @(posedge core_clk);
      fb_cycle <= 1'b0;
   endtask : cyc
endmodule : psp_fb_master
`default_nettype wire

// ==== tb/test_port_status_process_image.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "psp_defs.svh"
module test_port_status_process_image;
   import psp_pkg::*;
   logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, fb_cycle, irq, pd_wr_valid, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   psp_mode_t   mode [4];
   psp_err_t    err [4];
   logic [5:0]  len [4];
   logic [3:0]  halt, vld, ev, din;
   logic [1:0]  wp;
   logic [4:0]  wi;
   logic [7:0]  wd, mst;
   logic [7:0]  pd [8];
   int          err_total, total_checks, seed, i, j;
   psp_top i_psp_top (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_mode(mode),
      .port_err(err), .port_pd_len(len), .port_halted(halt), .port_pd_valid(vld), .port_event(ev),
      .port_din_pin(din), .pd_wr_valid(pd_wr_valid), .pd_wr_port(wp), .pd_wr_idx(wi), .pd_wr_data(wd),
      .module_state(mst), .fb_cycle(fb_cycle), .irq(irq));
   psp_fb_master i_psp_fb_master (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fb_cycle(fb_cycle));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   function automatic logic [7:0] sb(int p);
      psp_err_t code;
      code = (err[p] > PSP_ERR_PRE_OPERATE_PHASE) ? PSP_ERR_INTERNAL : err[p];
      return {code, ~vld[p], (mode[p] == PSP_MODE_DIN || mode[p] == PSP_MODE_DOUT) ? din[p] : halt[p], mode[p]};
   endfunction : sb
   task automatic conclude;
      $display("Checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      logic ok;
      i_psp_fb_master.xfer(w, a, d, q, e, ok);
      if (!ok) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
         conclude();
      end
   endtask : bus
   task automatic pulse_ev(input logic [3:0] v);
      @(posedge core_clk);
      ev <= v;
      @(posedge core_clk);
      ev <= 4'h0;
      repeat (2) @(posedge core_clk);
   endtask : pulse_ev
   initial begin
      seed = 78440;
      rst_n = 1'b0;
      {pd_wr_valid, wp, wi, wd, halt, vld, ev, din} = '0;
      mst = 8'h00;
      for (i = 0; i < 4; i++) begin
         mode[i] = PSP_MODE_OFF;
         err[i] = PSP_ERR_NONE;
         len[i] = 6'h00;
      end
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      bus(1'b0, `PSP_ADDR_MAP, 32'h0); chk(q, 32'h0);
      bus(1'b0, `PSP_ADDR_PD_BASE, 32'h0); chk(q, 32'h0);
      bus(1'b0, 12'h040, 32'h0); chk({31'h0, e}, 32'h1);
      bus(1'b0, 12'h002, 32'h0); chk({31'h0, e}, 32'h1);
      // ************************************************************
      // Random modes, error codes 0 to 14, random levels
      // ************************************************************
      for (j = 0; j < 12; j++) begin
         @(posedge core_clk);
         for (i = 0; i < 4; i++) begin
            mode[i] <= psp_mode_t'(2'($random(seed)));
            err[i] <= psp_err_t'(4'((j + i) % 16));
         end
         {halt, vld, din} <= 12'($random(seed));
         mst <= 8'($random(seed));
         repeat (3) @(posedge core_clk);
         i_psp_fb_master.cyc();
         bus(1'b0, `PSP_ADDR_PORT_STAT, 32'h0); chk(q, {sb(3), sb(2), sb(1), sb(0)});
      end
      // ************************************************************
      // Event flag, acknowledge, interrupt
      // ************************************************************
      bus(1'b1, `PSP_ADDR_IRQ_MASK, 32'h1);
      pulse_ev(4'h4);
      chk({31'h0, irq}, 32'h1);
      i_psp_fb_master.cyc();
      bus(1'b0, `PSP_ADDR_MOD_STATUS, 32'h0); chk(q, {16'h0, mst, 8'h01});
      bus(1'b1, `PSP_ADDR_CTRL, 32'h1);
      bus(1'b0, `PSP_ADDR_MOD_STATUS, 32'h0); chk(q, {16'h0, mst, 8'h00});
      bus(1'b1, `PSP_ADDR_IRQ_STAT, 32'h7);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, `PSP_ADDR_IRQ_MASK, 32'h0);
      pulse_ev(4'h1);
      chk({31'h0, irq}, 32'h0);
      bus(1'b0, `PSP_ADDR_IRQ_STAT, 32'h0); chk(q, 32'h1);
      // ************************************************************
      // Process data after configuration and reload
      // ************************************************************
      len[0] <= 6'd5;
      len[1] <= 6'd8;
      bus(1'b1, `PSP_ADDR_CFG, 32'h1);
      bus(1'b1, `PSP_ADDR_CTRL, 32'h2);
      bus(1'b0, `PSP_ADDR_MAP, 32'h0); chk(q, 32'h1);
      bus(1'b0, `PSP_ADDR_IRQ_STAT, 32'h0); chk(q, 32'h5);
      bus(1'b0, `PSP_ADDR_PD_LEN, 32'h0); chk(q, 32'h5);
      for (j = 0; j < 16; j++) begin
         @(posedge core_clk);
         if (j < 8) pd[j] = 8'($random(seed));
         pd_wr_valid <= 1'b1;
         wp <= 2'(j / 8);
         wi <= 5'(j % 8);
         wd <= pd[j % 8];
         @(posedge core_clk);
         pd_wr_valid <= 1'b0;
      end
      bus(1'b0, `PSP_ADDR_PD_BASE, 32'h0); chk(q, {pd[3], pd[2], pd[1], pd[0]});
      bus(1'b0, `PSP_ADDR_PD_BASE + 12'h004, 32'h0); chk(q, {24'h0, pd[4]});
      bus(1'b0, `PSP_ADDR_PD_BASE + 12'h020, 32'h0); chk(q, 32'h0);
      conclude();
   end
endmodule : test_port_status_process_image
bind psp_top psp_top_sva i_psp_top_sva (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire
